// ===== mt_sync_consts.vh
// Purpose: constants of the external multiturn read-in block
// Assumes: system clock of 10 MHz
// Notes:   times are kept in their own unit, counts derive from them
`ifndef MT_SYNC_CONSTS_VH
`define MT_SYNC_CONSTS_VH

// register offsets
`define ADDR_DIR_ERR      8'h0e
`define ADDR_OFFSET       8'h0f
`define ADDR_CHECK_CHAIN  8'h10

// field positions
`define DIR_INV_BIT       5
`define ERR_MODE_HI       7
`define ERR_MODE_LO       6
`define OFFSET_HI         7
`define OFFSET_LO         4
`define WIDTH_MODE_HI     3
`define WIDTH_MODE_LO     0
`define SYNC_LEN_HI       5
`define SYNC_LEN_LO       4
`define PERIODIC_BIT      6
`define CHAIN_EN_BIT      7

// reset values
`define RST_DIR_ERR       8'h00
`define RST_OFFSET        8'h00
`define RST_CHECK_CHAIN   8'h00
`define RST_PORT_A_MODE   3'h0
`define RST_REPLY_LENGTH  2'h0

// error bit evaluation codes
`define ERR_NONE          2'h0
`define ERR_LOW           2'h1
`define ERR_RSVD          2'h2
`define ERR_HIGH          2'h3

// port a modes that allow the pass-through
`define PA_BISS           3'h2
`define PA_SSI_ERR_LOW_MODE       3'h5
`define PA_EXT_SSI        3'h7

// first status register bits
`define ST_MISMATCH_BIT   0
`define ST_SWITCH_ERR_BIT 1
`define ST_READ_ERR_BIT   2

// timing
`define SYS_CLK_MHZ       10
`define MT_HALF_NS        500
`define MT_HALF_CYC       ((`MT_HALF_NS * `SYS_CLK_MHZ) / 1000)
`define MT_TIMEOUT_US     20
`define MT_TIMEOUT_CYC    (`MT_TIMEOUT_US * `SYS_CLK_MHZ)
`define CHECK_INTERVAL_US 10000
`define CHECK_INTERVAL_CYC (`CHECK_INTERVAL_US * `SYS_CLK_MHZ)

`endif

// ===== ssi_frame_reader.v
// Purpose: clocks one ssi frame in from the external turn sensor
// Assumes: data_in is already synchronised to clk
// Notes:   clock idles high; bits are taken msb first on rising edges
`timescale 1ns/1ps
`default_nettype none
`include "mt_sync_consts.vh"

module ssi_frame_reader (
  input  wire        clk,
  input  wire        arst_n,
  input  wire        start,
  input  wire [4:0]  len,
  input  wire        data_in,
  output reg         busy,
  output reg         done,
  output reg  [23:0] word,
  output reg         sclk
);

  localparam [1:0] R_IDLE = 2'h0;
  localparam [1:0] R_RUN  = 2'h1;
  localparam [1:0] R_GAP  = 2'h2;
  localparam [31:0] HALF_W = `MT_HALF_CYC;
  localparam [31:0] GAP_W  = `MT_TIMEOUT_CYC;
  localparam [7:0]  HALF   = HALF_W[7:0];
  localparam [7:0]  GAP    = GAP_W[7:0];

  reg [1:0] state_q;
  reg [7:0] div_q;
  reg [4:0] pulses_q;

  //////////////////////////////////////////////////////////////////////
  // frame sequencer; the first falling edge only latches the sensor, so the first rising edge takes no bit
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q  <= R_IDLE;
      div_q    <= 8'h00;
      pulses_q <= 5'h00;
      busy     <= 1'b0;
      done     <= 1'b0;
      word     <= 24'h000000;
      sclk     <= 1'b1;
    end else begin
      done <= 1'b0;
      case (state_q)
        R_IDLE: begin
          if (start && len != 5'h00) begin
            state_q  <= R_RUN;
            busy     <= 1'b1;
            sclk     <= 1'b0;
            div_q    <= 8'h00;
            pulses_q <= 5'h00;
            word     <= 24'h000000;
          end
        end
        R_RUN: begin
          if (div_q == HALF - 8'h01) begin
            div_q <= 8'h00;
            if (!sclk) begin
              sclk <= 1'b1;
              if (pulses_q != 5'h00)
                word <= {word[22:0], data_in};
              pulses_q <= pulses_q + 5'h01;
              if (pulses_q == len) begin
                state_q <= R_GAP;
                done    <= 1'b1;
              end
            end else begin
              sclk <= 1'b0;
            end
          end else begin
            div_q <= div_q + 8'h01;
          end
        end
        R_GAP: begin
          // clock held high so the sensor's monoflop can time out
          if (div_q == GAP - 8'h01) begin
            state_q <= R_IDLE;
            busy    <= 1'b0;
            div_q   <= 8'h00;
          end else begin
            div_q <= div_q + 8'h01;
          end
        end
        default: state_q <= R_IDLE;
      endcase
    end
  end

endmodule // ssi_frame_reader
`default_nettype wire

// ===== multiturn_sync_interface.v
// Purpose: reads, aligns and checks an external multiturn sensor word
// Assumes: period pulses and serial data come from logic on CLK_SYS
// Notes:   pins from outside pass two flip-flops before use
`timescale 1ns/1ps
`default_nettype none
`include "mt_sync_consts.vh"

module multiturn_sync_interface #(
  parameter CHECK_PERIOD_CYC = `CHECK_INTERVAL_CYC
) (
  input  wire        CLK_SYS,
  input  wire        ARST_N,
  input  wire [7:0]  REG_ADDR,
  input  wire [7:0]  REG_WDATA,
  input  wire        REG_WR,
  output reg  [7:0]  REG_RDATA,
  input  wire        TURN_VERIFY_CMD,
  input  wire        SWITCH_CMD,
  input  wire        SOFT_RESET_CMD,
  input  wire        STATUS_CLR,
  input  wire [2:0]  PENDING_PORT_A_MODE,
  input  wire [1:0]  PENDING_REPLY_LENGTH,
  input  wire        SSI_REPLY_OPTION,
  input  wire        PERIOD_UP,
  input  wire        PERIOD_DOWN,
  input  wire        SERIAL_DATA_IN,
  input  wire        MASTER_CLOCK_IN,
  input  wire        EXT_TURN_DATA_IN,
  output reg         EXT_TURN_CLOCK_OUT,
  output reg         SLAVE_DATA_OUT,
  output reg  [2:0]  PORT_A_MODE,
  output reg  [1:0]  REPLY_LENGTH,
  output reg  [7:0]  FIRST_STATUS_REG,
  output reg  [23:0] TURN_COUNT,
  output reg  [5:0]  SINGLE_TURN_EXT,
  output reg         TURN_VALID,
  output reg         CHAIN_ACTIVE
);

  localparam [1:0] S_BOOT = 2'h0;
  localparam [1:0] S_WAIT = 2'h1;
  localparam [1:0] S_RUN  = 2'h2;
  localparam [31:0] CHK_LAST_W = CHECK_PERIOD_CYC - 1;
  localparam [23:0] CHK_LAST   = CHK_LAST_W[23:0];

  // external data bits per width mode
  function [4:0] data_bits;
    input [3:0] m;
    begin
      case (m)
        4'h7:    data_bits = 5'd15;
        4'h8:    data_bits = 5'd16;
        4'h9:    data_bits = 5'd17;
        4'ha:    data_bits = 5'd18;
        4'hb:    data_bits = 5'd4;
        4'hc:    data_bits = 5'd8;
        4'hd:    data_bits = 5'd12;
        4'he:    data_bits = 5'd16;
        4'hf:    data_bits = 5'd18;
        default: data_bits = {1'b0, m};
      endcase
    end
  endfunction

  // low bits of the word that are singleturn, not turns
  function [2:0] st_bits;
    input [3:0] m;
    begin
      case (m)
        4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6: st_bits = m[2:0];
        4'h7:    st_bits = 3'd3;
        4'h8:    st_bits = 3'd4;
        4'h9:    st_bits = 3'd5;
        4'ha:    st_bits = 3'd6;
        default: st_bits = 3'd0;
      endcase
    end
  endfunction

  function [23:0] low_mask;
    input [4:0] n;
    begin
      low_mask = ~(24'hffffff << n);
    end
  endfunction

  //////////////////////////////////////////////////////////////////////
  // configuration registers
  reg [7:0] dir_err_q;
  reg [7:0] offset_q;
  reg [7:0] check_chain_q;

  wire       dir_inv   = dir_err_q[`DIR_INV_BIT];
  wire [1:0] err_mode  = dir_err_q[`ERR_MODE_HI:`ERR_MODE_LO];
  wire [3:0] ext_off   = offset_q[`OFFSET_HI:`OFFSET_LO];
  wire [3:0] wmode     = check_chain_q[`WIDTH_MODE_HI:`WIDTH_MODE_LO];
  wire [1:0] sync_code = check_chain_q[`SYNC_LEN_HI:`SYNC_LEN_LO];
  wire       periodic  = check_chain_q[`PERIODIC_BIT];
  wire       chain_en  = check_chain_q[`CHAIN_EN_BIT];

  always @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      dir_err_q     <= `RST_DIR_ERR;
      offset_q      <= `RST_OFFSET;
      check_chain_q <= `RST_CHECK_CHAIN;
      REG_RDATA     <= 8'h00;
    end else begin
      if (REG_WR && REG_ADDR == `ADDR_DIR_ERR)
        dir_err_q <= REG_WDATA;
      if (REG_WR && REG_ADDR == `ADDR_OFFSET)
        offset_q <= REG_WDATA;
      if (REG_WR && REG_ADDR == `ADDR_CHECK_CHAIN)
        check_chain_q <= REG_WDATA;
      case (REG_ADDR)
        `ADDR_DIR_ERR:     REG_RDATA <= dir_err_q;
        `ADDR_OFFSET:      REG_RDATA <= offset_q;
        `ADDR_CHECK_CHAIN: REG_RDATA <= check_chain_q;
        default:           REG_RDATA <= 8'h00;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // pin synchronisers; only the second stage is read
  reg ma_s1_q, ma_s2_q, md_s1_q, md_s2_q;
  always @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      ma_s1_q <= 1'b1;
      ma_s2_q <= 1'b1;
      md_s1_q <= 1'b0;
      md_s2_q <= 1'b0;
    end else begin
      ma_s1_q <= MASTER_CLOCK_IN;
      ma_s2_q <= ma_s1_q;
      md_s1_q <= EXT_TURN_DATA_IN;
      md_s2_q <= md_s1_q;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // frame length and field extraction
  wire [4:0] dbits = data_bits(wmode);
  wire [4:0] sbits = {3'b000, sync_code} + 5'd1;
  wire [4:0] ebits = (err_mode == `ERR_NONE) ? 5'd0 : 5'd1;
  wire [4:0] frame_len = (wmode == 4'h0) ? 5'd0 :
                         dbits + sbits + ebits;

  wire        rd_start;
  wire        rd_busy;
  wire        rd_done;
  wire [23:0] rd_word;
  wire        rd_sclk;

  ssi_frame_reader u_reader (
    .clk     (CLK_SYS),
    .arst_n  (ARST_N),
    .start   (rd_start),
    .len     (frame_len),
    .data_in (md_s2_q),
    .busy    (rd_busy),
    .done    (rd_done),
    .word    (rd_word),
    .sclk    (rd_sclk)
  );

  // error bit is the last bit clocked in, so it sits at bit 0
  wire err_bit = (err_mode == `ERR_LOW)  ? ~rd_word[0] :
                 (err_mode == `ERR_HIGH) ?  rd_word[0] : 1'b0;
  wire [23:0] ds_field = (rd_word >> ebits) & low_mask(dbits + sbits);
  // offset works on the sync bits, so it shifts the turn boundary
  wire [23:0] ds_adj   = (ds_field + {20'h00000, ext_off}) &
                         low_mask(dbits + sbits);
  wire [23:0] raw_val  = ds_adj >> sbits;
  wire [23:0] turn_val = dir_inv ? ((24'h000000 - raw_val) & low_mask(dbits))
                                 : raw_val;
  wire        mismatch = (turn_val & low_mask(dbits)) !=
                         (TURN_COUNT & low_mask(dbits));

  //////////////////////////////////////////////////////////////////////
  // read sequencer: startup load, then periodic or commanded checks
  reg [1:0]  state_q;
  reg        booted_q;
  reg        verify_req_q;
  reg [23:0] chk_cnt_q;
  reg        go_q;

  wire chain_ok = chain_en &&
                  (PORT_A_MODE == `PA_BISS ||
                   (PORT_A_MODE >= `PA_SSI_ERR_LOW_MODE &&
                    PORT_A_MODE <= `PA_EXT_SSI && SSI_REPLY_OPTION));
  assign rd_start = go_q;

  always @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      state_q      <= S_BOOT;
      booted_q     <= 1'b0;
      verify_req_q <= 1'b0;
      chk_cnt_q    <= 24'h000000;
      go_q         <= 1'b0;
      TURN_COUNT   <= 24'h000000;
      TURN_VALID   <= 1'b0;
      SINGLE_TURN_EXT <= 6'h00;
      FIRST_STATUS_REG <= 8'h00;
    end else begin
      go_q <= 1'b0;
      // status bits: a set in the clearing cycle wins
      if (STATUS_CLR)
        FIRST_STATUS_REG <= 8'h00;
      if (TURN_VERIFY_CMD)
        verify_req_q <= 1'b1;
      // counting goes on while a check frame is being read
      if (booted_q) begin
        if (PERIOD_UP && !PERIOD_DOWN)
          TURN_COUNT <= TURN_COUNT + 24'h000001;
        else if (PERIOD_DOWN && !PERIOD_UP)
          TURN_COUNT <= TURN_COUNT - 24'h000001;
      end
      // interval timer runs only while the periodic check is on
      if (!periodic || chk_cnt_q == CHK_LAST)
        chk_cnt_q <= 24'h000000;
      else
        chk_cnt_q <= chk_cnt_q + 24'h000001;
      case (state_q)
        S_BOOT: begin
          if (frame_len == 5'd0) begin
            state_q    <= S_RUN;       // no sensor: count on from the current TURN_COUNT
            booted_q   <= 1'b1;
            TURN_VALID <= 1'b1;
          end else if (!rd_busy && !chain_ok) begin
            go_q    <= 1'b1;
            state_q <= S_WAIT;
          end
        end
        S_WAIT: begin
          if (rd_done) begin
            if (err_bit) begin
              FIRST_STATUS_REG[`ST_READ_ERR_BIT] <= 1'b1;
              state_q <= booted_q ? S_RUN : S_BOOT;
            end else if (!booted_q) begin
              TURN_COUNT <= turn_val;
              SINGLE_TURN_EXT <= turn_val[5:0] &
                                 ~(6'h3f << st_bits(wmode));
              booted_q   <= 1'b1;
              TURN_VALID <= 1'b1;
              state_q    <= S_RUN;
            end else begin
              if (mismatch)
                FIRST_STATUS_REG[`ST_MISMATCH_BIT] <= 1'b1;
              state_q <= S_RUN;
            end
          end
        end
        S_RUN: begin
          // checks pause while the master owns the sensor link
          if (frame_len != 5'd0 && !chain_ok && !rd_busy &&
              (verify_req_q || (periodic && chk_cnt_q == CHK_LAST))) begin
            verify_req_q <= 1'b0;
            go_q    <= 1'b1;
            state_q <= S_WAIT;
          end
        end
        default: state_q <= S_BOOT;
      endcase
      // soft reset repeats the startup read; overrides the case above
      if (SOFT_RESET_CMD) begin
        state_q      <= S_BOOT;
        booted_q     <= 1'b0;
        verify_req_q <= 1'b0;
        TURN_VALID   <= 1'b0;
      end
      if (SWITCH_CMD && (chain_ok || rd_busy))
        FIRST_STATUS_REG[`ST_SWITCH_ERR_BIT] <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // interface mode switch, taken over on soft reset
  reg       switch_armed_q;
  always @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      switch_armed_q <= 1'b0;
      PORT_A_MODE    <= `RST_PORT_A_MODE;
      REPLY_LENGTH   <= `RST_REPLY_LENGTH;
    end else begin
      if (SWITCH_CMD && !chain_ok && !rd_busy)
        switch_armed_q <= 1'b1;
      if (SOFT_RESET_CMD && switch_armed_q) begin
        PORT_A_MODE    <= PENDING_PORT_A_MODE;
        REPLY_LENGTH   <= PENDING_REPLY_LENGTH;
        switch_armed_q <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // pin muxing; pass-through adds three system clocks of delay
  always @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      EXT_TURN_CLOCK_OUT <= 1'b1;
      SLAVE_DATA_OUT     <= 1'b0;
      CHAIN_ACTIVE       <= 1'b0;
    end else begin
      CHAIN_ACTIVE       <= chain_ok;
      EXT_TURN_CLOCK_OUT <= chain_ok ? ma_s2_q : rd_sclk;
      // sensor data leads the chain, so it answers as the first slave
      SLAVE_DATA_OUT     <= chain_ok ? md_s2_q :
                                       SERIAL_DATA_IN;
    end
  end

endmodule // multiturn_sync_interface
`default_nettype wire

// ===== mt_sync_props.sv
// Purpose: concurrent checks on the multiturn read-in block
// Assumes: one clock domain, reset asynchronous and active low
// Notes:   pass-through delay of three edges as set by the designer
`timescale 1ns/1ps
`default_nettype none
module mt_sync_props #(
  parameter CHECK_PERIOD_CYC = 200
) (
  input wire logic        CLK_SYS,
  input wire logic        ARST_N,
  input wire logic        SWITCH_CMD,
  input wire logic        SOFT_RESET_CMD,
  input wire logic        STATUS_CLR,
  input wire logic [2:0]  PENDING_PORT_A_MODE,
  input wire logic        PERIOD_UP,
  input wire logic        PERIOD_DOWN,
  input wire logic        MASTER_CLOCK_IN,
  input wire logic        EXT_TURN_DATA_IN,
  input wire logic        EXT_TURN_CLOCK_OUT,
  input wire logic        SLAVE_DATA_OUT,
  input wire logic [2:0]  PORT_A_MODE,
  input wire logic [7:0]  FIRST_STATUS_REG,
  input wire logic [23:0] TURN_COUNT,
  input wire logic        TURN_VALID,
  input wire logic        CHAIN_ACTIVE
);
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!ARST_N);
  ////////////////////////////////////////////////////////////
  // sensor clock low phase is five system cycles outside the chain
  a_clk_low_time: assert property (
    $fell(EXT_TURN_CLOCK_OUT) && !CHAIN_ACTIVE |->
    !EXT_TURN_CLOCK_OUT [*5] ##1 EXT_TURN_CLOCK_OUT)
    else $error("sensor clock low phase wrong");
  // pass-through lines lag their source by three edges
  a_chain_clock: assert property (
    CHAIN_ACTIVE [*4] |-> EXT_TURN_CLOCK_OUT == $past(MASTER_CLOCK_IN, 3))
    else $error("chain clock not passed through");
  a_chain_data: assert property (
    CHAIN_ACTIVE [*4] |-> SLAVE_DATA_OUT == $past(EXT_TURN_DATA_IN, 3))
    else $error("chain data not passed through");
  a_chain_modes: assert property (
    CHAIN_ACTIVE |-> PORT_A_MODE == 3'h2 || PORT_A_MODE >= 3'h5)
    else $error("chain active in a wrong mode");
  // status bits only fall on a clear
  a_status_sticky: assert property (
    |($past(FIRST_STATUS_REG) & ~FIRST_STATUS_REG) |-> $past(STATUS_CLR))
    else $error("status bit lost without clear");
  a_switch_refused: assert property (
    SWITCH_CMD && CHAIN_ACTIVE |=> FIRST_STATUS_REG[1])
    else $error("switch in chain not flagged");
  a_mode_on_soft: assert property (
    $changed(PORT_A_MODE) |-> $past(SOFT_RESET_CMD) &&
    PORT_A_MODE == $past(PENDING_PORT_A_MODE))
    else $error("mode changed without soft reset");
  a_count_step: assert property (
    PERIOD_UP && !PERIOD_DOWN && TURN_VALID |=>
    TURN_COUNT == $past(TURN_COUNT) + 24'h000001)
    else $error("counter missed an up step");
  c_chain_on: cover property (CHAIN_ACTIVE [*4]);
  c_mismatch: cover property ($rose(FIRST_STATUS_REG[0]));
  c_switch_err: cover property ($rose(FIRST_STATUS_REG[1]));
  c_mode_change: cover property ($changed(PORT_A_MODE));
endmodule // mt_sync_props
bind multiturn_sync_interface mt_sync_props #(
  .CHECK_PERIOD_CYC(CHECK_PERIOD_CYC)) mt_sync_props_i (
  .CLK_SYS(CLK_SYS), .ARST_N(ARST_N), .SWITCH_CMD(SWITCH_CMD),
  .SOFT_RESET_CMD(SOFT_RESET_CMD), .STATUS_CLR(STATUS_CLR),
  .PENDING_PORT_A_MODE(PENDING_PORT_A_MODE), .PERIOD_UP(PERIOD_UP),
  .PERIOD_DOWN(PERIOD_DOWN), .MASTER_CLOCK_IN(MASTER_CLOCK_IN),
  .EXT_TURN_DATA_IN(EXT_TURN_DATA_IN),
  .EXT_TURN_CLOCK_OUT(EXT_TURN_CLOCK_OUT),
  .SLAVE_DATA_OUT(SLAVE_DATA_OUT), .PORT_A_MODE(PORT_A_MODE),
  .FIRST_STATUS_REG(FIRST_STATUS_REG), .TURN_COUNT(TURN_COUNT),
  .TURN_VALID(TURN_VALID),
  .CHAIN_ACTIVE(CHAIN_ACTIVE));
`default_nettype wire

// ===== ssi_turn_sensor.sv
// Purpose: behavioural external turn sensor with an ssi output
// Assumes: clock idles high; a long high phase ends the frame
// Notes:   word and len are set by the bench before each read
`timescale 1ns/1ps
`default_nettype none
module ssi_turn_sensor (
  input  wire logic sclk,
  output var  logic sdo
);
  logic [23:0] word = 24'h000000;
  int          len = 1;
  int          n = 0;
  realtime     t_hi = 0.0;
  initial sdo = 1'b1;
  ////////////////////////////////////////////////////////////
  // after the last bit the line flips, so a stale bit never looks valid
  always @(posedge sclk) begin
    t_hi = $realtime;
    if (n > len) sdo <= #300 ~sdo;
  end
  // first fall latches the word, later falls shift it out msb first
  always @(negedge sclk) begin
    if ($realtime - t_hi > 1500.0) n = 0;  // monoflop expired
    n = n + 1;
    if (n >= 2 && n <= len + 1) sdo = word[len - n + 1];
  end
endmodule // ssi_turn_sensor
`default_nettype wire

// ===== multiturn_sync_interface_tb.sv
// Purpose: self-checking bench for the multiturn read-in block
// Assumes: sensor model answers on the sensor clock pin
// Notes:   check interval shortened to 200 cycles for the run
`timescale 1ns/1ps
`default_nettype none
module multiturn_sync_interface_tb;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [7:0]  wdata = 8'h00;
  logic        wr = 1'b0;
  logic [3:0]  cmds = 4'h0;  // verify, switch, soft reset, clear
  logic [2:0]  pmode = 3'h0;
  logic [1:0]  plen = 2'h0;
  logic        ropt = 1'b0;
  logic [1:0]  updn = 2'h0;
  logic        sdi = 1'b0;
  logic        sdi_q = 1'b0;  // value the design sampled last edge
  logic        mclk = 1'b1;
  logic [7:0]  cfg [3];
  wire  logic  tdi, eclk, sdo, tvalid, chain;
  wire  logic [7:0]  rdata, status;
  wire  logic [2:0]  amode;
  wire  logic [1:0]  rlen;
  wire  logic [23:0] tcount;
  wire  logic [5:0]  stx;
  int seed = 32'hcf78b107;
  int n_fail = 0;
  int compares = 0;
  int cyc = 0;
  int i, j, k, w, s, e, off, d, sy, r, t, mask, cnt, inv, bad, eb, mis;
  multiturn_sync_interface #(.CHECK_PERIOD_CYC(200))
    multiturn_sync_interface_i (
    .CLK_SYS(clk), .ARST_N(arst_n), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_WR(wr), .REG_RDATA(rdata), .TURN_VERIFY_CMD(cmds[3]),
    .SWITCH_CMD(cmds[2]), .SOFT_RESET_CMD(cmds[1]), .STATUS_CLR(cmds[0]),
    .PENDING_PORT_A_MODE(pmode), .PENDING_REPLY_LENGTH(plen),
    .SSI_REPLY_OPTION(ropt), .PERIOD_UP(updn[1]), .PERIOD_DOWN(updn[0]),
    .SERIAL_DATA_IN(sdi), .MASTER_CLOCK_IN(mclk), .EXT_TURN_DATA_IN(tdi),
    .EXT_TURN_CLOCK_OUT(eclk), .SLAVE_DATA_OUT(sdo), .PORT_A_MODE(amode),
    .REPLY_LENGTH(rlen), .FIRST_STATUS_REG(status), .TURN_COUNT(tcount),
    .SINGLE_TURN_EXT(stx), .TURN_VALID(tvalid), .CHAIN_ACTIVE(chain));
  ssi_turn_sensor ssi_turn_sensor_i (.sclk(eclk), .sdo(tdi));
  ////////////////////////////////////////////////////////////
  // 100 ns system clock
  initial forever #50 clk = ~clk;
  // inputs move on falling edges, away from the sampling edge
  task automatic tick(input int n);
    repeat (n) begin
      @(negedge clk);
      sdi_q = sdi;
      sdi = 1'($random(seed));
    end
  endtask
  task automatic chk(input string nm, input logic [23:0] exp,
                     input logic [23:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] v);
    addr = a;
    wdata = v;
    wr = 1'b1;
    tick(1);
    wr = 1'b0;
    tick(1);  // strobe low for an edge before the next write
  endtask
  task automatic rreg(input logic [7:0] a, input logic [7:0] v);
    addr = a;
    tick(2);
    chk("register", {16'h0, v}, {16'h0, rdata});
  endtask
  task automatic cmd(input logic [3:0] c);
    cmds = c;
    tick(1);
    cmds = 4'h0;
  endtask
  // one verify: wait for the frame, then for a long high idle phase
  task automatic vrun(input int bd, input int ms);
    int n;
    int h;
    n = 0;
    h = 0;
    cmd(4'b1000);
    while (eclk === 1'b1 && n < 100) begin
      tick(1);
      n++;
    end
    chk("frame start", 0, {23'h0, eclk});
    while (h < 20 && n < 700) begin
      tick(1);
      n++;
      h = (eclk === 1'b1) ? h + 1 : 0;
    end
    tick(3);
    chk("read error", bd, {23'h0, status[2]});
    if (bd == 0) chk("mismatch", ms, {23'h0, status[0]});
    cmd(4'b0001);
    tick(200);  // the sensor needs its gap before another frame
  endtask
  // soft reset restarts the startup read; may wait out a sensor gap
  task automatic boot(input logic [7:0] c, input int l, input int v);
    ssi_turn_sensor_i.len = l;
    ssi_turn_sensor_i.word = v;
    wreg(8'h10, c);
    cmd(4'b0010);
    chk("valid at boot", 0, {23'h0, tvalid});
    tick(300);
    chk("valid", 1, {23'h0, tvalid});
  endtask
  task automatic finish_test();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      finish_test();
    end
  end
  ////////////////////////////////////////////////////////////
  initial begin
    cnt = 0;
    tick(3);
    arst_n = 1'b1;
    tick(1);
    chk("valid", 1, {23'h0, tvalid});
    for (k = 0; k < 3; k++) rreg(8'(8'h0e + k), 8'h00);
    wreg(8'h11, 8'hff);
    rreg(8'h11, 8'h00);
    chk("idle clock", 1, {23'h0, eclk});
    // random words and offsets, codes stepped by the loop index, half of them agreeing with the count
    for (i = 0; i < 12; i++) begin
      repeat (3) begin
        j = $random(seed) & 1;
        updn = j ? 2'b10 : 2'b01;
        cnt = j ? cnt + 1 : cnt - 1;
        tick(1);
        updn = 2'b00;
        tick(1);
      end
      chk("turn count", cnt[23:0], tcount);
      w = (i % 5 == 4) ? 18 : (i % 5 + 1) * 4;
      s = i % 4 + 1;
      e = (i + i / 4) % 4;
      inv = $random(seed) & 1;
      off = $random(seed) & 15;
      mask = (1 << w) - 1;
      r = inv ? -cnt & mask : cnt & mask;
      d = i[0] ? (r - (off >> s)) & mask : $random(seed) & mask;
      sy = i[0] ? 0 : $random(seed) & ((1 << s) - 1);
      t = (((d << s) | sy) + off) >> s;
      mis = (inv ? -t & mask : t & mask) != (cnt & mask);
      bad = (e % 2 == 1) && (i % 3 == 0);
      eb = (e == 1) ? !bad : (e == 3) ? bad : $random(seed) & 1;
      ssi_turn_sensor_i.len = w + s + (e != 0);
      ssi_turn_sensor_i.word = e ? (((d << s) | sy) << 1) | eb : (d << s) | sy;
      cfg[0] = {e[1:0], inv[0], 5'h00};
      cfg[1] = {off[3:0], 4'h0};
      cfg[2] = {2'b00, 2'(s - 1), 4'(i % 5 + 11)};
      for (k = 0; k < 3; k++) wreg(8'(8'h0e + k), cfg[k]);
      for (k = 0; k < 3; k++) rreg(8'(8'h0e + k), cfg[k]);
      vrun(bad, mis);
    end
    // periodic check with a word one above the count
    wreg(8'h0e, 8'h00);
    wreg(8'h0f, 8'h00);
    // startup loads: five singleturn bits, then a four-bit turn word
    d = $random(seed) & 31;
    boot(8'h05, 6, d << 1);
    chk("singleturn bits", d, {18'h0, stx});
    d = $random(seed) & 15;
    boot(8'h0b, 5, d << 1);
    cnt = d;
    chk("boot load", cnt[23:0], tcount);
    ssi_turn_sensor_i.len = 5;
    ssi_turn_sensor_i.word = ((cnt + 1) & 15) << 1;
    wreg(8'h10, 8'h4b);
    k = 0;
    while (status[0] !== 1'b1 && k < 1500) begin
      tick(1);
      k++;
    end
    chk("periodic", 1, {23'h0, status[0]});
    wreg(8'h10, 8'h0b);
    tick(400);
    cmd(4'b0001);
    tick(800);
    chk("no periodic", 0, {23'h0, status[0]});
    // every interface mode through switch, soft reset and chain enable
    wreg(8'h10, 8'h00);
    for (i = 0; i < 8; i++) begin
      pmode = i[2:0];
      plen = i[1:0];
      cmd(4'b0100);
      tick(2);
      chk("switch error", 0, {23'h0, status[1]});
      cmd(4'b0010);
      tick(2);
      chk("mode", {19'h0, pmode, plen}, {19'h0, amode, rlen});
      chk("slave data", {23'h0, sdi_q}, {23'h0, sdo});
      wreg(8'h10, 8'h80);  // chain first, option after
      ropt = 1'($random(seed));  // the option gates ssi modes
      tick(3);
      k = (i == 2) || (i >= 5 && ropt);
      chk("chain", k, {23'h0, chain});
      if (k) begin
        tick(20);  // master lets the timeout pass
        repeat (8) begin
          mclk = ~mclk;
          tick(4);
          chk("chain clock", {23'h0, mclk}, {23'h0, eclk});
        end
        cmd(4'b0100);
        tick(2);
        chk("switch refused", 1, {23'h0, status[1]});
        cmd(4'b0001);
      end
      wreg(8'h10, 8'h00);
      ropt = 1'b0;
      tick(4);
    end
    finish_test();
  end
endmodule // multiturn_sync_interface_tb
`default_nettype wire
